// file: vpi_cfg.svh
// Constants for the video pre-amp serial control block
// Overview of operation
// - Source bit 0: vblank from vertical pin
// - Source bit 1: sandcastle vblank, brightness out
// - Pin mode: no brightness out, still mixed
// - Global bit 0 blanks video completely
// - Global bit 1 turns output stage off
// - Global bit 3 halves colour DAC range
// - Global bit 4 adds half brightness DAC
// - Slave address DCh write, DDh read
// - Slave acknowledges its own address byte and every byte the master sends after it
// - Increment bit 0 clear: next register address
// - Read starts at stored index, increments
// - Master acknowledges each read data byte but the last
// - Vblank enable ORs vertical with horizontal blank
// - Contrast, brightness writes apply during retrace
`ifndef VPI_CFG_SVH
`define VPI_CFG_SVH

// ****************************************
// Bus address and register indices
// ****************************************
`define VPI_SLAVE_ADDR   7'h6E
`define VPI_REG_RGAIN    4'h0
`define VPI_REG_BGAIN    4'h1
`define VPI_REG_GGAIN    4'h2
`define VPI_REG_CONTRAST 4'h3
`define VPI_REG_DAC1     4'h4
`define VPI_REG_DAC2     4'h5
`define VPI_REG_DAC3     4'h6
`define VPI_REG_BRIGHTNESS_DAC     4'h7
`define VPI_REG_OFFSET   4'h8
`define VPI_REG_GLOBAL   4'h9
`define VPI_REG_AUTO_INCREMENT_DISABLE     4'hA
`define VPI_REG_VBL      4'hB
`define VPI_REG_SRST     4'hF

// ****************************************
// Reset values
// ****************************************
`define VPI_RST_GAIN   8'h60
`define VPI_RST_DAC    8'h80
`define VPI_RST_OFFSET 8'h15
`define VPI_RST_GLOBAL 8'h00
`define VPI_RST_AUTO_INCREMENT_DISABLE   8'h00
`define VPI_RST_VBL    8'h04

// ****************************************
// Field positions
// ****************************************
`define VPI_GLB_BLANK  0
`define VPI_GLB_OFF    1
`define VPI_GLB_HALF   3
`define VPI_GLB_MIX    4
`define VPI_INC_DIS    0
`define VPI_VBL_EN     1
`define VPI_VBL_SRC    2
`define VPI_SRST_BIT   0

`endif

// file: vpi_pkg.sv
// Types for the video pre-amp serial control block
package vpi_pkg;
    // Byte engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRX,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } vpi_state_t;
endpackage

// file: vpi_i2c_ctrl.sv
// Serial slave, register file and control-bit logic of the pre-amp
`timescale 1ns/100ps
`include "vpi_cfg.svh"

module vpi_i2c_ctrl (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       scl,              // Bus clock level, sampled
    input  wire logic       sdaIn,            // Bus data level
    output logic            sdaOut,           // Always 0 when driving
    output logic            sdaOe,            // High pulls data low
    input  wire logic       vertPinIn,        // Logic vblank on vertical pin
    input  wire logic       sandcastleVblank, // Vblank decoded from clamp pin
    input  wire logic       horzBlank,        // Horizontal blank
    output logic            vertPinOe,        // Brightness DAC drives vertical pin
    output logic            videoBlank,       // Outputs at blank level
    output logic            outputStageOn,    // Low leaves output at high impedance
    output logic [6:0]      redGain,
    output logic [6:0]      blueGain,
    output logic [6:0]      greenGain,
    output logic [6:0]      contrast,         // Active contrast value
    output logic [8:0]      colorBalanceDac1, // Colour DAC levels, 9 bits for mix
    output logic [8:0]      colorBalanceDac2,
    output logic [8:0]      colorBalanceDac3,
    output logic [7:0]      brightnessDac,    // Active brightness DAC value
    output logic [7:0]      offsetOsd         // Offset and OSD contrast field
);

    // ****************************************
    // Bus line sampling
    // ****************************************
    logic sclQ_r, sdaQ_r;  // Previous levels for edge and condition detect
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclQ_r <= 1'b1;
            sdaQ_r <= 1'b1;
        end else begin
            sclQ_r <= scl;
            sdaQ_r <= sdaIn;
        end
    end
    wire sclRise = scl & ~sclQ_r;
    wire sclFall = ~scl & sclQ_r;
    wire startCond = scl & sclQ_r & sdaQ_r & ~sdaIn;
    wire stopCond  = scl & sclQ_r & ~sdaQ_r & sdaIn;

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] regs_r [0:15];     // Shadow copies written by the bus
    logic [6:0] contrastAct_r;     // Contrast as applied to video
    logic [7:0] dac4Act_r;         // Brightness as applied
    logic [3:0] index_r;           // Register pointer
    logic [7:0] shift_r;           // Incoming or outgoing byte
    logic [2:0] bitCnt_r;          // Position of the current bit in the byte
    logic       gotIndex_r;        // Index byte already taken
    logic       nackMaster_r;      // Master ended the read
    vpi_pkg::vpi_state_t state_r;

    // Reads of unused indices return zero
    function automatic logic [7:0] readReg(input logic [3:0] idx);
        if (idx == `VPI_REG_CONTRAST)
            readReg = {1'b0, contrastAct_r};
        else if (idx == `VPI_REG_BRIGHTNESS_DAC)
            readReg = dac4Act_r;
        else if (idx <= `VPI_REG_VBL)
            readReg = regs_r[idx];
        else
            readReg = 8'h00;
    endfunction

    // Pointer step, frozen when increment is disabled
    function automatic logic [3:0] nextIndex(input logic [3:0] idx);
        if (regs_r[`VPI_REG_AUTO_INCREMENT_DISABLE][`VPI_INC_DIS])
            nextIndex = idx;
        else
            nextIndex = idx + 4'h1;
    endfunction

    // Word that the pointer addresses, for the first bit of a read byte
    wire [7:0] rdWord = readReg(index_r);

    wire byteDone = sclRise && (bitCnt_r == 3'h0);
    wire [7:0] rxByte = {shift_r[6:0], sdaIn};
    wire vbEnable = regs_r[`VPI_REG_VBL][`VPI_VBL_EN];
    wire vbSource = regs_r[`VPI_REG_VBL][`VPI_VBL_SRC];
    // Vertical blank from pin or from the clamp-pin decoder
    wire vBlankNow = vbSource ? sandcastleVblank : vertPinIn;
    wire swReset = (state_r == vpi_pkg::ST_WRX) && byteDone && gotIndex_r
                   && (index_r == `VPI_REG_SRST) && rxByte[`VPI_SRST_BIT];

    // ****************************************
    // Byte engine
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r      <= vpi_pkg::ST_IDLE;
            bitCnt_r     <= 3'h7;
            shift_r      <= 8'h00;
            gotIndex_r   <= 1'b0;
            nackMaster_r <= 1'b0;
            index_r      <= 4'h0;
        end else if (stopCond) begin
            state_r <= vpi_pkg::ST_IDLE;
        end else if (startCond) begin
            state_r    <= vpi_pkg::ST_ADDR;
            bitCnt_r   <= 3'h7;
            gotIndex_r <= 1'b0;
        end else begin
            unique case (state_r)
                vpi_pkg::ST_IDLE: begin
                end
                vpi_pkg::ST_ADDR: begin
                    if (sclRise) begin
                        shift_r  <= rxByte;
                        bitCnt_r <= bitCnt_r - 3'h1;
                    end
                    if (byteDone) begin
                        // Only our address is acknowledged
                        if (rxByte[7:1] == `VPI_SLAVE_ADDR)
                            state_r <= vpi_pkg::ST_ADDR_ACK;
                        else
                            state_r <= vpi_pkg::ST_IDLE;
                    end
                end
                vpi_pkg::ST_ADDR_ACK: begin
                    // Leave acknowledge slot on its falling edge
                    if (sclFall && sdaOe) begin
                        bitCnt_r <= 3'h7;
                        if (shift_r[0]) begin
                            state_r <= vpi_pkg::ST_RD;
                            shift_r <= readReg(index_r);
                        end else begin
                            state_r <= vpi_pkg::ST_WRX;
                        end
                    end
                end
                vpi_pkg::ST_WRX: begin
                    if (sclRise) begin
                        shift_r  <= rxByte;
                        bitCnt_r <= bitCnt_r - 3'h1;
                    end
                    if (byteDone) begin
                        state_r <= vpi_pkg::ST_WR_ACK;
                        if (!gotIndex_r) begin
                            index_r    <= rxByte[3:0];
                            gotIndex_r <= 1'b1;
                        end else begin
                            index_r <= nextIndex(index_r);
                        end
                    end
                end
                vpi_pkg::ST_WR_ACK: begin
                    if (sclFall && sdaOe) begin
                        state_r  <= vpi_pkg::ST_WRX;
                        bitCnt_r <= 3'h7;
                    end
                end
                vpi_pkg::ST_RD: begin
                    // Each bit stands from one falling edge to the next; bit 0 leads into the ack slot
                    if (sclFall) begin
                        if (bitCnt_r == 3'h0) begin
                            state_r <= vpi_pkg::ST_RD_ACK;
                            index_r <= index_r + 4'h1;
                        end else begin
                            shift_r  <= {shift_r[6:0], 1'b0};
                            bitCnt_r <= bitCnt_r - 3'h1;
                        end
                    end
                end
                vpi_pkg::ST_RD_ACK: begin
                    // Master acknowledge decides whether to continue
                    if (sclRise)
                        nackMaster_r <= sdaIn;
                    if (sclFall) begin
                        if (nackMaster_r) begin
                            state_r <= vpi_pkg::ST_IDLE;
                        end else begin
                            state_r  <= vpi_pkg::ST_RD;
                            bitCnt_r <= 3'h7;
                            shift_r  <= readReg(index_r);
                        end
                    end
                end
                default: state_r <= vpi_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Data line drive
    // ****************************************
    // Changed only after a falling bus clock: a move in the high phase
    // would look like a start or stop to every device on the bus
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sdaOe  <= 1'b0;
            sdaOut <= 1'b0;
        end else if (startCond || stopCond) begin
            sdaOe <= 1'b0;
        end else if (sclFall) begin
            unique case (state_r)
                vpi_pkg::ST_ADDR_ACK: begin
                    // Ack slot opens; on its end a read puts out bit 7 at once
                    if (sdaOe)
                        sdaOe <= shift_r[0] & ~rdWord[7];
                    else
                        sdaOe <= 1'b1;
                end
                vpi_pkg::ST_WR_ACK:
                    sdaOe <= ~sdaOe;
                vpi_pkg::ST_RD:
                    // Next bit, or release after bit 0 for the master
                    sdaOe <= (bitCnt_r != 3'h0) & ~shift_r[6];
                vpi_pkg::ST_RD_ACK:
                    // Next byte only after a master acknowledge
                    sdaOe <= ~nackMaster_r & ~rdWord[7];
                default:
                    sdaOe <= 1'b0;
            endcase
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n || swReset) begin
            for (int i = 0; i < 16; i++)
                regs_r[i] <= 8'h00;
            regs_r[`VPI_REG_RGAIN]    <= `VPI_RST_GAIN;
            regs_r[`VPI_REG_BGAIN]    <= `VPI_RST_GAIN;
            regs_r[`VPI_REG_GGAIN]    <= `VPI_RST_GAIN;
            regs_r[`VPI_REG_CONTRAST] <= `VPI_RST_GAIN;
            regs_r[`VPI_REG_DAC1]     <= `VPI_RST_DAC;
            regs_r[`VPI_REG_DAC2]     <= `VPI_RST_DAC;
            regs_r[`VPI_REG_DAC3]     <= `VPI_RST_DAC;
            regs_r[`VPI_REG_BRIGHTNESS_DAC]     <= `VPI_RST_DAC;
            regs_r[`VPI_REG_OFFSET]   <= `VPI_RST_OFFSET;
            regs_r[`VPI_REG_GLOBAL]   <= `VPI_RST_GLOBAL;
            regs_r[`VPI_REG_AUTO_INCREMENT_DISABLE]     <= `VPI_RST_AUTO_INCREMENT_DISABLE;
            regs_r[`VPI_REG_VBL]      <= `VPI_RST_VBL;
        end else if (state_r == vpi_pkg::ST_WRX && byteDone && gotIndex_r
                     && index_r <= `VPI_REG_VBL) begin
            regs_r[index_r] <= rxByte;
        end
    end

    // Contrast and brightness wait for retrace when vblank is enabled
    always_ff @(posedge clk) begin
        if (!reset_n || swReset) begin
            contrastAct_r <= 7'(`VPI_RST_GAIN);
            dac4Act_r     <= `VPI_RST_DAC;
        end else if (!vbEnable || vBlankNow) begin
            contrastAct_r <= regs_r[`VPI_REG_CONTRAST][6:0];
            dac4Act_r     <= regs_r[`VPI_REG_BRIGHTNESS_DAC];
        end
    end

    // ****************************************
    // Video control outputs
    // ****************************************
    logic [8:0] mix;  // Half brightness term, or zero
    always_comb begin
        mix = regs_r[`VPI_REG_GLOBAL][`VPI_GLB_MIX] ? {2'b00, dac4Act_r[7:1]} : 9'h000;
    end

    // Colour DAC level with optional half range and brightness mix
    function automatic logic [8:0] dacLevel(input logic [7:0] code, input logic [8:0] add);
        if (regs_r[`VPI_REG_GLOBAL][`VPI_GLB_HALF])
            dacLevel = {2'b00, code[7:1]} + add;
        else
            dacLevel = {1'b0, code} + add;
    endfunction

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            videoBlank       <= 1'b0;
            outputStageOn    <= 1'b1;
            vertPinOe        <= 1'b1;
            redGain          <= 7'h00;
            blueGain         <= 7'h00;
            greenGain        <= 7'h00;
            contrast         <= 7'h00;
            colorBalanceDac1 <= 9'h000;
            colorBalanceDac2 <= 9'h000;
            colorBalanceDac3 <= 9'h000;
            brightnessDac    <= 8'h00;
            offsetOsd        <= 8'h00;
        end else begin
            videoBlank <= regs_r[`VPI_REG_GLOBAL][`VPI_GLB_BLANK]
                          | horzBlank | (vbEnable & vBlankNow);
            outputStageOn    <= ~regs_r[`VPI_REG_GLOBAL][`VPI_GLB_OFF];
            vertPinOe        <= vbSource;
            redGain          <= regs_r[`VPI_REG_RGAIN][6:0];
            blueGain         <= regs_r[`VPI_REG_BGAIN][6:0];
            greenGain        <= regs_r[`VPI_REG_GGAIN][6:0];
            contrast         <= contrastAct_r;
            colorBalanceDac1 <= dacLevel(regs_r[`VPI_REG_DAC1], mix);
            colorBalanceDac2 <= dacLevel(regs_r[`VPI_REG_DAC2], mix);
            colorBalanceDac3 <= dacLevel(regs_r[`VPI_REG_DAC3], mix);
            brightnessDac    <= dac4Act_r;
            offsetOsd        <= regs_r[`VPI_REG_OFFSET];
        end
    end

endmodule // vpi_i2c_ctrl

// file: vpi_i2c_ctrl_asserts.sv
// Port-level concurrent checks for the pre-amp serial control block
`timescale 1ns/100ps

module vpi_i2c_ctrl_asserts (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       scl,              // Bus clock level
    input wire logic       sdaOut,           // Data value when driving
    input wire logic       sdaOe,            // Slave pulls data low
    input wire logic       horzBlank,        // Horizontal blank in
    input wire logic       videoBlank,       // Outputs at blank level
    input wire logic       outputStageOn,    // Output stage powered
    input wire logic       vertPinOe,        // Brightness DAC on vertical pin
    input wire logic [6:0] redGain,          // Red gain register
    input wire logic [8:0] colorBalanceDac1  // First colour DAC level
);
    // ****************************************
    // Single domain: one clock, one reset
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Open drain: only a low may be driven
    chk_sda_only_low: assert property (sdaOut == 1'h0)
        else $error("data driven high");
    // Drive edges fall in the low phase of the bus clock
    chk_ack_scl_low: assert property ($changed(sdaOe) |-> !scl)
        else $error("data drive changed while bus clock high");
    // An acknowledge stands across the high phase
    chk_ack_held: assert property ($rose(scl) && sdaOe |-> sdaOe [*3])
        else $error("acknowledge dropped during high phase");
    // Horizontal blank always reaches the outputs one clock later
    chk_hblank_or: assert property ($past(horzBlank) && $past(reset_n) |-> videoBlank)
        else $error("horizontal blank not applied");
    // Defaults appear shortly after reset
    chk_reset_defaults: assert property ($rose(reset_n) |-> ##[0:2]
        (redGain == 7'h60 && colorBalanceDac1 == 9'h080 && vertPinOe && outputStageOn))
        else $error("reset defaults not shown");
    // Control bits only move on a stored data byte
    chk_stage_on_write: assert property ($changed(outputStageOn) |-> scl)
        else $error("output stage moved outside a write");
    chk_vpin_on_write: assert property ($changed(vertPinOe) |-> scl)
        else $error("vertical pin drive moved outside a write");
    chk_gain_on_write: assert property ($changed(redGain) |-> scl)
        else $error("gain moved outside a write");
    // Full code plus half brightness never passes 17Eh
    chk_dac_ceiling: assert property (colorBalanceDac1 <= 9'h17E)
        else $error("colour DAC sum out of range");
endmodule // vpi_i2c_ctrl_asserts

// file: vpi_i2c_master.sv
// Bus master model standing in for the system microcontroller
`timescale 1ns/100ps

module vpi_i2c_master (
    input wire logic clk,
    input wire logic sdaOe, // Slave pulling data low
    output logic     scl,   // Bus clock, idles high
    output logic     sdaIn  // Resolved data line level
);
    logic sdaDrv = 1'h1; // Master data, high means released

    initial scl = 1'h1;

    // Pull-up wins only when nobody pulls low
    assign sdaIn = sdaDrv & ~sdaOe;

    // One bit: data set in low phase, sampled mid high phase
    task automatic put_bit(input logic b, output logic seen);
        repeat (2) @(posedge clk);
        sdaDrv <= b;
        repeat (3) @(posedge clk);
        scl <= 1'h1;
        repeat (3) @(posedge clk);
        seen = sdaIn;
        repeat (2) @(posedge clk);
        scl <= 1'h0;
    endtask

    // Start (data falls) or stop (data rises) while clock high
    task automatic bus_cond(input logic isStart);
        repeat (2) @(posedge clk);
        sdaDrv <= isStart;
        repeat (3) @(posedge clk);
        scl <= 1'h1;
        repeat (3) @(posedge clk);
        sdaDrv <= ~isStart;
        repeat (5) @(posedge clk);
        if (isStart) begin
            scl <= 1'h0;
        end
    endtask

    // Byte out MSB first, then release for the slave acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], dummy);
        end
        put_bit(1'h1, ack);
    endtask

    // Byte in, then master acknowledge, or no-acknowledge on the last
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'h1, b[i]);
        end
        put_bit(last, dummy);
    endtask
endmodule // vpi_i2c_master

// file: tb.sv
// Self-checking bench for the pre-amp serial control block
`timescale 1ns/100ps

module tb;
    logic clk = 1'h0;
    logic reset_n, scl, sdaIn, sdaOut, sdaOe, vertPinIn, sandcastleVblank, horzBlank;
    logic vertPinOe, videoBlank, outputStageOn;
    logic [6:0] redGain, blueGain, greenGain, contrast;
    logic [8:0] colorBalanceDac1, colorBalanceDac2, colorBalanceDac3;
    logic [7:0] brightnessDac, offsetOsd;
    logic [7:0] q [3];               // Read-back bytes
    int         errTotal = 0;        // Mismatches
    int         testsRun = 0;        // Comparisons
    int         cycles = 0;          // Timeout counter
    // Global control steps and {colour DAC, blank, stage on}; 03h after 02h stage off
    logic [7:0]  glbVal [7] = '{8'h08, 8'h10, 8'h18, 8'h01, 8'h02, 8'h03, 8'h00};
    logic [10:0] glbExp [7] = '{{9'h020, 2'h1}, {9'h081, 2'h1}, {9'h060, 2'h1}, {9'h041, 2'h3},
                                {9'h041, 2'h0}, {9'h041, 2'h2}, {9'h041, 2'h1}};
    // Vblank modes, pins {hblank, vertical, sandcastle}, expected {pin drive, blank}
    logic [7:0]  vblVal [7] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h04, 8'h06, 8'h06};
    logic [2:0]  pinVal [7] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2};
    logic [1:0]  vblExp [7] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h2};

    always #20 clk = ~clk;

    vpi_i2c_ctrl u_vpi_i2c_ctrl (.clk(clk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .vertPinIn(vertPinIn), .sandcastleVblank(sandcastleVblank), .horzBlank(horzBlank),
        .vertPinOe(vertPinOe), .videoBlank(videoBlank), .outputStageOn(outputStageOn), .redGain(redGain),
        .blueGain(blueGain), .greenGain(greenGain), .contrast(contrast), .colorBalanceDac1(colorBalanceDac1),
        .colorBalanceDac2(colorBalanceDac2), .colorBalanceDac3(colorBalanceDac3),
        .brightnessDac(brightnessDac), .offsetOsd(offsetOsd));

    vpi_i2c_master u_vpi_i2c_master (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrapUp();
        $display("Comparisons %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errTotal++;
            wrapUp();
        end
    end

    // ****************************************
    // Bus transfers
    // ****************************************
    task automatic wr(input logic [7:0] idx, input logic [7:0] d [3], input int n);
        logic ack;
        u_vpi_i2c_master.bus_cond(1'h1);
        u_vpi_i2c_master.put_byte(8'hDC, ack);
        check(ack, 1'h0);
        u_vpi_i2c_master.put_byte(idx, ack);
        check(ack, 1'h0);
        for (int i = 0; i < n; i++) begin
            u_vpi_i2c_master.put_byte(d[i], ack);
            check(ack, 1'h0);
        end
        u_vpi_i2c_master.bus_cond(1'h0);
    endtask

    task automatic wr1(input logic [7:0] idx, input logic [7:0] v);
        wr(idx, '{v, 8'h00, 8'h00}, 1);
        repeat (3) @(posedge clk);
    endtask

    // Index-only write and stop, then a fresh read transfer
    task automatic rd(input logic [7:0] idx, input int n);
        wr(idx, '{8'h00, 8'h00, 8'h00}, 0);
        u_vpi_i2c_master.bus_cond(1'h1);
        u_vpi_i2c_master.put_byte(8'hDD, q[0][0]);
        check(q[0][0], 1'h0);
        for (int i = 0; i < n; i++) begin
            u_vpi_i2c_master.get_byte(i == n - 1, q[i]);
        end
        u_vpi_i2c_master.bus_cond(1'h0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_n = 1'h0;
        vertPinIn = 1'h0;
        sandcastleVblank = 1'h0;
        horzBlank = 1'h0;
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge clk);
        check({1'h0, redGain, 1'h0, contrast, brightnessDac, offsetOsd}, 32'h60608015);
        check({vertPinOe, outputStageOn, videoBlank, colorBalanceDac1}, {3'h6, 9'h080});
        // Foreign address is left unanswered
        u_vpi_i2c_master.bus_cond(1'h1);
        u_vpi_i2c_master.put_byte(8'hDA, q[0][0]);
        check(q[0][0], 1'h1);
        u_vpi_i2c_master.bus_cond(1'h0);
        // Burst write walks the index, read walks it again
        wr(8'h00, '{8'h11, 8'h22, 8'h33}, 3);
        repeat (3) @(posedge clk);
        check({1'h0, redGain, 1'h0, blueGain, 1'h0, greenGain}, 24'h112233);
        rd(8'h00, 3);
        check({q[0], q[1], q[2]}, 24'h112233);
        // Fixed index: second byte overwrites the first
        wr1(8'h0A, 8'h01);
        wr(8'h04, '{8'h40, 8'h41, 8'h00}, 2);
        repeat (3) @(posedge clk);
        check({colorBalanceDac1, colorBalanceDac2}, {9'h041, 9'h080});
        wr1(8'h0A, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr1(8'h09, glbVal[i]);
            check({colorBalanceDac1, videoBlank, outputStageOn}, glbExp[i]);
        end
        wr1(8'h09, 8'h10);
        for (int i = 0; i < 7; i++) begin
            wr1(8'h0B, vblVal[i]);
            {horzBlank, vertPinIn, sandcastleVblank} <= pinVal[i];
            repeat (3) @(posedge clk);
            check({vertPinOe, videoBlank, colorBalanceDac1}, {vblExp[i], 9'h081});
        end
        {horzBlank, vertPinIn, sandcastleVblank} <= 3'h0;
        // Contrast and brightness wait for vertical retrace
        wr1(8'h03, 8'h25);
        wr1(8'h07, 8'h20);
        check({contrast, brightnessDac}, {7'h60, 8'h80});
        sandcastleVblank <= 1'h1;
        repeat (4) @(posedge clk);
        check({contrast, brightnessDac, colorBalanceDac1}, {7'h25, 8'h20, 9'h051});
        sandcastleVblank <= 1'h0;
        // Soft reset brings back every default; reads past the map give zero
        wr1(8'h0F, 8'h01);
        check({1'h0, redGain, 1'h0, contrast, brightnessDac, offsetOsd}, 32'h60608015);
        check({vertPinOe, outputStageOn, videoBlank, colorBalanceDac3, sdaOut}, {3'h6, 9'h080, 1'h0});
        rd(8'h0A, 3);
        check({q[0], q[1], q[2]}, 24'h000400);
        wrapUp();
    end
endmodule // tb

bind vpi_i2c_ctrl vpi_i2c_ctrl_asserts u_vpi_i2c_ctrl_asserts (.clk(clk), .reset_n(reset_n), .scl(scl),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .horzBlank(horzBlank), .videoBlank(videoBlank),
    .outputStageOn(outputStageOn), .vertPinOe(vertPinOe), .redGain(redGain),
    .colorBalanceDac1(colorBalanceDac1));
